// File: mtvo_map.svh
/*
 * Register offsets, field positions, reset values and widths of the
 * timer value and overflow count register set.
 * Assumes an 8-bit special-function-register bus with 8-bit addresses.
 */
`ifndef MTVO_MAP_SVH
`define MTVO_MAP_SVH

`define MTVO_ADDR_COMPARE      8'h94
`define MTVO_ADDR_OVF_LOW      8'ha1
`define MTVO_ADDR_OVF_MID      8'ha2
`define MTVO_ADDR_OVF_HIGH     8'ha3
`define MTVO_ADDR_PERIOD_LOW   8'ha4
`define MTVO_ADDR_PERIOD_HIGH  8'ha5
`define MTVO_ADDR_TIMER_LOW    8'ha6
`define MTVO_ADDR_TIMER_HIGH   8'ha7
`define MTVO_ADDR_CONFIG       8'hc3

`define MTVO_CFG_RUN_BIT       0
`define MTVO_CFG_SYNC_BIT      1
`define MTVO_CFG_COMPARE_SOURCE_SELECT_BIT     3
`define MTVO_OVF_HIGH_WIDTH    4

`define MTVO_RST_TIMER         16'h0000
`define MTVO_RST_PERIOD        16'hffff
`define MTVO_RST_OVF           20'h00000
`define MTVO_RST_BYTE          8'h00
`define MTVO_RST_SYNC          1'b1

`endif

// File: mtvo_pkg.sv
/*
 * Types of the timer value and overflow count block.
 * Assumes the constants of mtvo_map.svh for every number.
 */
package mtvo_pkg;

	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} mtvo_sfr_req_s;

	typedef struct packed {
		logic [15:0] timer;
		logic [15:0] period;
		logic [19:0] ovf;
		logic [19:0] ovf_latch;
		logic [15:0] pause;
		logic [7:0]  cmp;
		logic [7:0]  tl_stage;
		logic [7:0]  hi_latch;
		logic [7:0]  of0_stage;
		logic [7:0]  of1_stage;
		logic [7:0]  rdata;
		logic        rvalid;
		logic        run;
		logic        sync;
		logic        compare_source_select;
		logic        cmp_evt;
		logic        ovf_evt;
	} mtvo_state_s;

endpackage

// File: mtvo_compare.sv
/*
 * Byte compare of the timer against the compare value.
 * Assumes the caller presents the timer value that will be registered next.
 */
`timescale 1ns/1ps

module mtvo_compare (
	input  wire logic [15:0] timer,
	input  wire logic        compare_source_select,
	input  wire logic [7:0]  cmp_value,
	output logic             match
);
	logic [7:0] sel_byte;

	always_comb begin
		sel_byte = compare_source_select ? timer[7:0] : timer[15:8];
		match    = (sel_byte == cmp_value);
	end
endmodule // mtvo_compare

// File: mtvo_regs.sv
/*
 * Timer value, delta pause, byte compare and 20-bit overflow count
 * registers on the special-function-register bus.
 * Assumes one read or write strobe per cycle, held for one cycle,
 * and a same-clock bus master.
 */
// How it works
// - Reading the timer low byte returns it and freezes the high byte for a later read.
// - Writing the timer high byte while running forms a delta from it and the staged low byte.
// - An applied delta stops counting for exactly that many clock cycles, then counting resumes.
// - Writing the timer low byte while running only stages the byte until the high byte is written.
// - Writing the timer low byte while idle loads the counter's low eight bits.
// - A compare event fires when a timer or compare value change makes the selected timer byte equal the compare value.
// - The compare selector picks bits 15:8 when zero and bits 7:0 when one.
// - The 20-bit overflow count steps by one when the incremented timer reaches the period or more.
// - The period high and low registers set bits 15:8 and 7:0 of the period.
// - Reading the overflow low byte latches the whole count for the middle and high reads.
// - Writing the overflow high register, idle or running, forces the count to the staged bytes.
// - An increment coinciding with that forcing write stores the written value plus one.
// - Writes to the overflow low and middle bytes are staged until the high byte is written.
// - The run bit selects idle at zero and run at one, and reads back the timer state.
`timescale 1ns/1ps
`include "mtvo_map.svh"

module mtvo_regs (
	input  wire logic                  core_clk,
	input  wire logic                  srst,
	input  wire logic                  ce,
	input  wire mtvo_pkg::mtvo_sfr_req_s sfr_req,
	output logic [7:0]                 sfr_rdata,
	output logic                       sfr_rvalid,
	output logic                       run_state,
	output logic                       compare_event,
	output logic                       overflow_event
);
	localparam mtvo_pkg::mtvo_state_s RST = '{
		timer: `MTVO_RST_TIMER, period: `MTVO_RST_PERIOD, ovf: `MTVO_RST_OVF,
		ovf_latch: `MTVO_RST_OVF, pause: `MTVO_RST_TIMER, cmp: `MTVO_RST_BYTE,
		tl_stage: `MTVO_RST_BYTE, hi_latch: `MTVO_RST_BYTE, of0_stage: `MTVO_RST_BYTE,
		of1_stage: `MTVO_RST_BYTE, rdata: `MTVO_RST_BYTE, rvalid: 1'b0, run: 1'b0,
		sync: `MTVO_RST_SYNC, compare_source_select: 1'b0, cmp_evt: 1'b0, ovf_evt: 1'b0};

	mtvo_pkg::mtvo_state_s st;
	mtvo_pkg::mtvo_state_s next_st;
	logic [15:0]           next_timer;
	logic [15:0]           timer_inc;
	logic [7:0]            next_cmp;
	logic                  next_compare_source_select;
	logic                  tick;
	logic                  wrap;
	logic                  cmp_match;

	function automatic logic wr_at(input mtvo_pkg::mtvo_sfr_req_s r, input logic [7:0] a);
		wr_at = r.wr && (r.addr == a);
	endfunction

	function automatic logic rd_at(input mtvo_pkg::mtvo_sfr_req_s r, input logic [7:0] a);
		rd_at = r.rd && (r.addr == a);
	endfunction

	// Timer path, kept apart so the compare sees the value about to be stored
	always_comb begin
		tick      = st.run && (st.pause == 16'h0000);
		timer_inc = st.timer + 16'h0001;
		wrap      = tick && (timer_inc >= st.period);
		next_timer = st.timer;
		if (tick) begin
			next_timer = wrap ? 16'h0000 : timer_inc;
		end
		if (!st.run && wr_at(sfr_req, `MTVO_ADDR_TIMER_LOW)) begin
			next_timer[7:0] = sfr_req.wdata;
		end
		if (!st.run && wr_at(sfr_req, `MTVO_ADDR_TIMER_HIGH)) begin
			next_timer[15:8] = sfr_req.wdata;
		end
		next_cmp   = wr_at(sfr_req, `MTVO_ADDR_COMPARE) ? sfr_req.wdata : st.cmp;
		next_compare_source_select = wr_at(sfr_req, `MTVO_ADDR_CONFIG) ?
			sfr_req.wdata[`MTVO_CFG_COMPARE_SOURCE_SELECT_BIT] : st.compare_source_select;
	end

	mtvo_compare u_compare (
		.timer     (next_timer),
		.compare_source_select     (next_compare_source_select),
		.cmp_value (next_cmp),
		.match     (cmp_match)
	);

	always_comb begin
		next_st         = st;
		next_st.timer   = next_timer;
		next_st.cmp     = next_cmp;
		next_st.compare_source_select   = next_compare_source_select;
		next_st.rvalid  = sfr_req.rd;
		next_st.ovf_evt = wrap;
		// Event only when the timer moves or is loaded, or the compare value changes, into a match
		next_st.cmp_evt = cmp_match && (next_timer != st.timer || next_cmp != st.cmp);
		if (st.run && st.pause != 16'h0000) begin
			next_st.pause = st.pause - 16'h0001;
		end
		if (wrap) begin
			next_st.ovf = st.ovf + 20'h00001;
		end
		if (wr_at(sfr_req, `MTVO_ADDR_TIMER_LOW)) begin
			next_st.tl_stage = sfr_req.wdata;
		end
		if (st.run && wr_at(sfr_req, `MTVO_ADDR_TIMER_HIGH)) begin
			next_st.pause = {sfr_req.wdata, st.tl_stage};
		end
		if (wr_at(sfr_req, `MTVO_ADDR_OVF_LOW)) begin
			next_st.of0_stage = sfr_req.wdata;
		end
		if (wr_at(sfr_req, `MTVO_ADDR_OVF_MID)) begin
			next_st.of1_stage = sfr_req.wdata;
		end
		if (wr_at(sfr_req, `MTVO_ADDR_OVF_HIGH)) begin
			next_st.ovf = {sfr_req.wdata[`MTVO_OVF_HIGH_WIDTH-1:0], st.of1_stage,
				st.of0_stage} + {19'h00000, wrap};
		end
		if (wr_at(sfr_req, `MTVO_ADDR_PERIOD_LOW)) begin
			next_st.period[7:0] = sfr_req.wdata;
		end
		if (wr_at(sfr_req, `MTVO_ADDR_PERIOD_HIGH)) begin
			next_st.period[15:8] = sfr_req.wdata;
		end
		if (wr_at(sfr_req, `MTVO_ADDR_CONFIG)) begin
			next_st.run  = sfr_req.wdata[`MTVO_CFG_RUN_BIT];
			next_st.sync = sfr_req.wdata[`MTVO_CFG_SYNC_BIT];
			if (!sfr_req.wdata[`MTVO_CFG_RUN_BIT]) begin
				next_st.pause = 16'h0000;
			end
		end
		if (sfr_req.rd) begin
			unique case (sfr_req.addr)
				`MTVO_ADDR_TIMER_LOW: begin
					next_st.rdata    = st.timer[7:0];
					next_st.hi_latch = st.timer[15:8];
				end
				`MTVO_ADDR_TIMER_HIGH:  next_st.rdata = st.hi_latch;
				`MTVO_ADDR_COMPARE:     next_st.rdata = st.cmp;
				`MTVO_ADDR_OVF_LOW: begin
					next_st.rdata     = st.ovf[7:0];
					next_st.ovf_latch = st.ovf;
				end
				`MTVO_ADDR_OVF_MID:     next_st.rdata = st.ovf_latch[15:8];
				`MTVO_ADDR_OVF_HIGH:
					next_st.rdata = {4'h0, st.ovf_latch[19:16]};
				`MTVO_ADDR_PERIOD_LOW:  next_st.rdata = st.period[7:0];
				`MTVO_ADDR_PERIOD_HIGH: next_st.rdata = st.period[15:8];
				`MTVO_ADDR_CONFIG:
					next_st.rdata = {4'h0, st.compare_source_select, 1'b0, st.sync, st.run};
				default:                next_st.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st <= RST;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign sfr_rdata      = st.rdata;
	assign sfr_rvalid     = st.rvalid;
	assign run_state      = st.run;
	assign compare_event  = st.cmp_evt;
	assign overflow_event = st.ovf_evt;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	low_read_latch_a: assert property (ce && rd_at(sfr_req, `MTVO_ADDR_TIMER_LOW) |=>
		sfr_rdata == $past(st.timer[7:0]) && st.hi_latch == $past(st.timer[15:8]))
		else $error("timer low read did not latch high byte");
	delta_form_a: assert property (ce && st.run && wr_at(sfr_req, `MTVO_ADDR_TIMER_HIGH) |=>
		st.pause == {$past(sfr_req.wdata), $past(st.tl_stage)})
		else $error("delta not formed from staged low byte");
	pause_hold_a: assert property (ce && st.run && st.pause != 16'h0000 |=>
		st.timer == $past(st.timer))
		else $error("timer moved during delta pause");
	run_low_stage_a: assert property (ce && st.run && wr_at(sfr_req, `MTVO_ADDR_TIMER_LOW) |=>
		st.tl_stage == $past(sfr_req.wdata) &&
		st.pause == ($past(st.pause) == 16'h0000 ? 16'h0000 : $past(st.pause) - 16'h0001))
		else $error("running low write had an effect");
	high_read_a: assert property (ce && rd_at(sfr_req, `MTVO_ADDR_TIMER_HIGH) |=>
		sfr_rdata == $past(st.hi_latch))
		else $error("timer high read did not return the frozen byte");
	ovf_mid_read_a: assert property (ce && rd_at(sfr_req, `MTVO_ADDR_OVF_MID) |=>
		sfr_rdata == $past(st.ovf_latch[15:8]))
		else $error("overflow middle read did not return the latched byte");
	idle_load_a: assert property (ce && !st.run && wr_at(sfr_req, `MTVO_ADDR_TIMER_LOW) |=>
		st.timer[7:0] == $past(sfr_req.wdata) && st.timer[15:8] == $past(st.timer[15:8]))
		else $error("idle low write not loaded");
	idle_high_a: assert property (ce && !st.run && wr_at(sfr_req, `MTVO_ADDR_TIMER_HIGH) |=>
		st.timer[15:8] == $past(sfr_req.wdata))
		else $error("idle high write not loaded");
	compare_hit_a: assert property (compare_event |->
		(st.compare_source_select ? st.timer[7:0] : st.timer[15:8]) == st.cmp)
		else $error("compare event without a match");
	ovf_step_a: assert property (ce && wrap && !wr_at(sfr_req, `MTVO_ADDR_OVF_HIGH) |=>
		st.ovf == $past(st.ovf) + 20'h00001 && st.timer == 16'h0000 && overflow_event)
		else $error("overflow count did not step");
	period_wr_a: assert property (ce && wr_at(sfr_req, `MTVO_ADDR_PERIOD_HIGH) |=>
		st.period[15:8] == $past(sfr_req.wdata))
		else $error("period high not written");
	ovf_latch_a: assert property (ce && rd_at(sfr_req, `MTVO_ADDR_OVF_LOW) |=>
		st.ovf_latch == $past(st.ovf))
		else $error("overflow count not latched");
	ovf_force_a: assert property (ce && wr_at(sfr_req, `MTVO_ADDR_OVF_HIGH) |=>
		st.ovf == {$past(sfr_req.wdata[3:0]), $past(st.of1_stage), $past(st.of0_stage)}
		+ {19'h00000, $past(wrap)})
		else $error("overflow count not forced");
	ovf_stage_a: assert property (ce && wr_at(sfr_req, `MTVO_ADDR_OVF_MID) && !wrap |=>
		st.ovf == $past(st.ovf))
		else $error("staged overflow byte changed the count");
	run_bit_a: assert property (ce && wr_at(sfr_req, `MTVO_ADDR_CONFIG) |=>
		run_state == $past(sfr_req.wdata[0]))
		else $error("run bit not taken");

	c_delta_pause: cover property (st.run && st.pause == 16'h0003 ##3 tick);
	c_overflow: cover property (overflow_event);
	c_compare: cover property (compare_event && st.run);
	c_force_inc: cover property (ce && wrap && wr_at(sfr_req, `MTVO_ADDR_OVF_HIGH));
	c_match_low: cover property (compare_event && st.compare_source_select);
endmodule // mtvo_regs

// File: mtvo_sfr_host.sv
/*
 * Bus master model standing in for the processor core on the register bus.
 * Assumes the same core_clk as the register block and one strobe per cycle.
 */
`timescale 1ns/1ps

module mtvo_sfr_host (
	input  wire logic               core_clk,
	input  wire logic [7:0]         sfr_rdata,
	input  wire logic               sfr_rvalid,
	output mtvo_pkg::mtvo_sfr_req_s req
);
	initial req = '0;

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		req <= '{a, 1'b1, 1'b0, d};
		@(posedge core_clk);
		req <= '0;
	endtask

	// Answer stands the cycle after the taking edge; taken at the next edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		req <= '{a, 1'b0, 1'b1, 8'h00};
		@(posedge core_clk);
		req <= '0;
		@(posedge core_clk);
		d = (sfr_rvalid === 1'b1) ? sfr_rdata : 8'hxx;
	endtask
endmodule // mtvo_sfr_host

// File: mtvo_regs_tb.sv
/*
 * Self-checking bench for the timer value and overflow count registers.
 * Assumes mtvo_sfr_host as bus master and the map of mtvo_map.svh.
 */
`timescale 1ns/1ps

module mtvo_regs_tb;
	logic                    core_clk;
	logic                    srst;
	logic                    ce;
	mtvo_pkg::mtvo_sfr_req_s sfr_req;
	logic [7:0]              sfr_rdata;
	logic                    sfr_rvalid;
	logic                    run_state;
	logic                    compare_event;
	logic                    overflow_event;
	int                      errors;
	int                      total_checks;
	int                      cmp_cnt;
	logic [7:0]              v0;
	logic [7:0]              v1;
	logic [7:0]              v2;
	logic [7:0]              v3;

	mtvo_regs DUT (.core_clk(core_clk), .srst(srst), .ce(ce), .sfr_req(sfr_req),
		.sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid), .run_state(run_state),
		.compare_event(compare_event), .overflow_event(overflow_event));
	mtvo_sfr_host P (.core_clk(core_clk), .sfr_rdata(sfr_rdata),
		.sfr_rvalid(sfr_rvalid), .req(sfr_req));

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		if (srst) begin
			cmp_cnt <= 0;
		end else if (compare_event === 1'b1) begin
			cmp_cnt <= cmp_cnt + 1;
		end
	end

	task chk(input logic [7:0] s, input logic [7:0] e);
		total_checks++;
		if (s !== e) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task results;
		if (errors == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task reset_values;
		P.rd(8'hc3, v0); chk(v0, 8'h02);
		P.rd(8'ha6, v0); chk(v0, 8'h00);
		P.rd(8'ha4, v0); chk(v0, 8'hff);
		P.rd(8'ha3, v0); chk(v0, 8'h00);
		P.rd(8'h00, v0); chk(v0, 8'h00);
	endtask

	task idle_load;
		P.wr(8'ha6, 8'h34);
		P.wr(8'ha7, 8'h12);
		P.rd(8'ha6, v0); chk(v0, 8'h34);
		P.rd(8'ha7, v0); chk(v0, 8'h12);
	endtask

	task compare_select;
		int start;
		start = cmp_cnt;
		P.wr(8'h94, 8'h12);
		P.wr(8'hc3, 8'h08);
		P.wr(8'h94, 8'h34);
		P.wr(8'hc3, 8'h00);
		P.wr(8'h94, 8'h33);
		chk(8'(cmp_cnt - start), 8'h02);
	endtask

	// High byte read must return the value frozen at the low read
	task high_latch;
		P.wr(8'ha6, 8'hf8);
		P.wr(8'ha7, 8'h12);
		P.wr(8'hc3, 8'h01);
		P.rd(8'ha6, v0);
		repeat (10) @(posedge core_clk);
		P.rd(8'ha7, v1);
		chk({3'b000, v0[7:3]}, 8'h1f);
		chk(v1, 8'h12);
		P.rd(8'hc3, v0); chk(v0, 8'h01);
	endtask

	// Same bus spacing with and without a delta of 3
	task delta_pause;
		P.rd(8'ha6, v0);
		repeat (4) P.wr(8'h00, 8'h55);
		P.rd(8'ha6, v1);
		P.rd(8'ha6, v2);
		P.wr(8'ha6, 8'h03);
		P.wr(8'ha7, 8'h00);
		repeat (2) P.wr(8'h00, 8'h55);
		P.rd(8'ha6, v3);
		chk(8'(v3 - v2), 8'(v1 - v0 - 8'h03));
	endtask

	task overflow_steps;
		P.wr(8'hc3, 8'h00);
		P.wr(8'ha4, 8'h10);
		P.wr(8'ha5, 8'h00);
		P.wr(8'ha6, 8'h00);
		P.wr(8'ha7, 8'h00);
		P.wr(8'hc3, 8'h01);
		P.rd(8'ha1, v0);
		repeat (160) @(posedge core_clk);
		P.rd(8'ha1, v1);
		chk(v1 - v0, 8'h0a);
	endtask

	task overflow_write;
		P.wr(8'hc3, 8'h00);
		P.wr(8'ha1, 8'h55);
		P.wr(8'ha2, 8'h66);
		P.rd(8'ha1, v0);
		P.rd(8'ha2, v0); chk(v0, 8'h00);
		P.wr(8'ha3, 8'h07);
		P.rd(8'ha1, v0); chk(v0, 8'h55);
		P.rd(8'ha2, v0); chk(v0, 8'h66);
		P.rd(8'ha3, v0); chk(v0, 8'h07);
	endtask

	// A write while the clock enable is low must be ignored
	task enable_hold;
		@(posedge core_clk);
		ce <= 1'b0;
		P.wr(8'h94, 8'h5a);
		ce <= 1'b1;
		P.rd(8'h94, v0); chk(v0, 8'h33);
	endtask

	initial begin
		errors = 0;
		total_checks = 0;
		ce = 1'b1;
		srst = 1'b1;
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		reset_values();
		idle_load();
		compare_select();
		high_latch();
		delta_pause();
		overflow_steps();
		overflow_write();
		enable_hold();
		results();
	end

	initial begin
		#500us;
		errors++;
		results();
	end
endmodule // mtvo_regs_tb
